// File: timer8_cfg.svh
// Constants for the 8-bit compare and waveform timer
`ifndef TIMER8_CFG_SVH
`define TIMER8_CFG_SVH

`define ADDR_W          3
`define OFS_CTRL        3'h0
`define OFS_COUNT       3'h1
`define OFS_COMPARE     3'h2
`define OFS_FLAGS       3'h3
`define OFS_PORT        3'h4

`define CTRL_MODE_LSB   0
`define CTRL_ACT_LSB    2
`define CTRL_PRESC_LSB  4
`define CTRL_FORCE_BIT  7
`define FLAG_OVF_BIT    0
`define FLAG_MATCH_BIT  1
`define PORT_VAL_BIT    0
`define PORT_DIR_BIT    1

`define COUNT_RST       8'h00
`define COMPARE_RST     8'h00
`define COUNT_MAX       8'hFF
`define COUNT_BOTTOM    8'h00
`define COUNT_STEP      8'h01

`define PRESC_W         10
`define PRESC_RST       10'h000
`define PRESC_STEP      10'h001
`define PRESC_MASK_8    10'h007
`define PRESC_MASK_64   10'h03F
`define PRESC_MASK_256  10'h0FF
`define PRESC_MASK_1024 10'h3FF

`endif

// File: timer8_pkg.sv
// Types for the 8-bit compare and waveform timer
package timer8_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL         = 2'h0,
    MODE_PHASE_PWM      = 2'h1,
    MODE_CLEAR_ON_MATCH = 2'h2,
    MODE_FAST_PWM       = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR  = 2'h2,
    ACT_SET    = 2'h3
  } action_t;

  typedef enum logic [2:0] {
    PRESC_STOP    = 3'h0,
    PRESC_DIV1    = 3'h1,
    PRESC_DIV8    = 3'h2,
    PRESC_DIV64   = 3'h3,
    PRESC_DIV256  = 3'h4,
    PRESC_DIV1024 = 3'h5
  } prescale_t;

endpackage

// File: timer8_compare_waveform_unit.sv
// 8-bit timer with one compare channel and waveform output
`timescale 1ns/100ps
`default_nettype none
`include "timer8_cfg.svh"

module timer8_compare_waveform_unit
  import timer8_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  input  wire logic               clk_en,
  input  wire logic [`ADDR_W-1:0] addr,
  input  wire logic [7:0]         wdata,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output var  logic [7:0]         rdata,
  output var  logic               pin_out,
  output var  logic               pin_oe,
  output var  logic               overflow_flag,
  output var  logic               match_flag
);

  mode_t                 waveform_mode_select;
  action_t               output_action_select;
  prescale_t             prescale_select;
  logic [7:0]            count_value;
  logic [7:0]            compare_value;
  logic [7:0]            compare_buffer;
  logic                  compare_output_state;
  logic                  port_value;
  logic                  pin_direction_bit;
  logic                  match_blocked;
  logic [`PRESC_W-1:0]   prescale_count;

  logic                  ctrl_wr;
  logic                  count_wr;
  logic                  compare_wr;
  logic                  flags_wr;
  logic                  port_wr;
  logic                  timer_tick;
  logic                  is_pwm;
  logic                  match_hit;
  logic                  wrap;
  logic                  force_match_strobe;
  logic [7:0]            next_count;
  logic                  next_state;
  logic [7:0]            read_mux;

  // Tick once every (mask + 1) enabled clocks
  function automatic logic prescale_hit(prescale_t sel, logic [`PRESC_W-1:0] cnt);
    logic hit;
    hit = 1'b0;
    case (sel)
      PRESC_DIV1:    hit = 1'b1;
      PRESC_DIV8:    hit = (cnt & `PRESC_MASK_8) == `PRESC_MASK_8;
      PRESC_DIV64:   hit = (cnt & `PRESC_MASK_64) == `PRESC_MASK_64;
      PRESC_DIV256:  hit = (cnt & `PRESC_MASK_256) == `PRESC_MASK_256;
      PRESC_DIV1024: hit = (cnt & `PRESC_MASK_1024) == `PRESC_MASK_1024;
      default:       hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Set, clear or toggle as a match does outside the PWM modes
  function automatic logic action_result(action_t act, logic cur);
    logic res;
    res = cur;
    case (act)
      ACT_TOGGLE: res = ~cur;
      ACT_CLEAR:  res = 1'b0;
      ACT_SET:    res = 1'b1;
      default:    res = cur;
    endcase
    return res;
  endfunction

  // Address decode; a frozen clock enable drops the access
  always_comb begin
    ctrl_wr    = 1'b0;
    count_wr   = 1'b0;
    compare_wr = 1'b0;
    flags_wr   = 1'b0;
    port_wr    = 1'b0;
    if (clk_en && wr_en) begin
      if (addr == `OFS_CTRL) begin
        ctrl_wr = 1'b1;
      end else if (addr == `OFS_COUNT) begin
        count_wr = 1'b1;
      end else if (addr == `OFS_COMPARE) begin
        compare_wr = 1'b1;
      end else if (addr == `OFS_FLAGS) begin
        flags_wr = 1'b1;
      end else if (addr == `OFS_PORT) begin
        port_wr = 1'b1;
      end
    end
  end

  always_comb begin
    read_mux = 8'h00;
    if (addr == `OFS_CTRL) begin
      read_mux[`CTRL_MODE_LSB +: 2]  = waveform_mode_select;
      read_mux[`CTRL_ACT_LSB +: 2]   = output_action_select;
      read_mux[`CTRL_PRESC_LSB +: 3] = prescale_select;
    end else if (addr == `OFS_COUNT) begin
      read_mux = count_value;
    end else if (addr == `OFS_COMPARE) begin
      read_mux = compare_buffer;
    end else if (addr == `OFS_FLAGS) begin
      read_mux[`FLAG_OVF_BIT]   = overflow_flag;
      read_mux[`FLAG_MATCH_BIT] = match_flag;
    end else if (addr == `OFS_PORT) begin
      read_mux[`PORT_VAL_BIT] = port_value;
      read_mux[`PORT_DIR_BIT] = pin_direction_bit;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      rdata <= rd_en ? read_mux : 8'h00;
    end
  end

  // Control register; action select takes effect with no buffering
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      waveform_mode_select <= MODE_NORMAL;
      output_action_select <= ACT_NONE;
      prescale_select      <= PRESC_STOP;
    end else if (ctrl_wr) begin
      waveform_mode_select <= mode_t'(wdata[`CTRL_MODE_LSB +: 2]);
      output_action_select <= action_t'(wdata[`CTRL_ACT_LSB +: 2]);
      prescale_select      <= prescale_t'(wdata[`CTRL_PRESC_LSB +: 3]);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_value        <= 1'b0;
      pin_direction_bit <= 1'b0;
    end else if (port_wr) begin
      port_value        <= wdata[`PORT_VAL_BIT];
      pin_direction_bit <= wdata[`PORT_DIR_BIT];
    end
  end

  // Prescaler runs free on every enabled clock
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale_count <= `PRESC_RST;
    end else if (clk_en) begin
      prescale_count <= prescale_count + `PRESC_STEP;
    end
  end

  assign timer_tick = clk_en && prescale_hit(prescale_select, prescale_count);

  assign is_pwm = (waveform_mode_select == MODE_FAST_PWM) ||
                  (waveform_mode_select == MODE_PHASE_PWM);

  assign match_hit = timer_tick && (count_value == compare_value) && !match_blocked;

  assign wrap = timer_tick && (count_value == `COUNT_MAX);

  // Force acts only outside the PWM modes
  assign force_match_strobe = ctrl_wr && wdata[`CTRL_FORCE_BIT] && !is_pwm;

  always_comb begin
    next_count = count_value;
    case (waveform_mode_select)
      MODE_CLEAR_ON_MATCH: begin
        // Only an exact match clears; a missed top runs on to the wrap
        next_count = match_hit ? `COUNT_BOTTOM : count_value + `COUNT_STEP;
      end
      MODE_FAST_PWM: begin
        next_count = count_value + `COUNT_STEP;
      end
      default: begin
        next_count = count_value + `COUNT_STEP;
      end
    endcase
  end

  // Software write wins over counting
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_value <= `COUNT_RST;
    end else if (count_wr) begin
      count_value <= wdata;
    end else if (timer_tick) begin
      count_value <= next_count;
    end
  end

  // Blocks the compare match on the first tick after a count write, even while stopped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      match_blocked <= 1'b0;
    end else if (count_wr) begin
      match_blocked <= 1'b1;
    end else if (timer_tick) begin
      match_blocked <= 1'b0;
    end
  end

  // Buffered in PWM modes, reloaded when the count wraps
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      compare_buffer <= `COMPARE_RST;
      compare_value  <= `COMPARE_RST;
    end else begin
      if (compare_wr) begin
        compare_buffer <= wdata;
      end
      if (compare_wr && !is_pwm) begin
        compare_value <= wdata;
      end else if (is_pwm && wrap) begin
        compare_value <= compare_wr ? wdata : compare_buffer;
      end
    end
  end

  always_comb begin
    next_state = compare_output_state;
    if (force_match_strobe) begin
      next_state = action_result(output_action_select, compare_output_state);
    end else if (waveform_mode_select == MODE_FAST_PWM) begin
      // Bottom wins when both fall in one tick, so max compare holds level
      if (match_hit && output_action_select == ACT_CLEAR) begin
        next_state = 1'b0;
      end else if (match_hit && output_action_select == ACT_SET) begin
        next_state = 1'b1;
      end
      if (wrap && output_action_select == ACT_CLEAR) begin
        next_state = 1'b1;
      end else if (wrap && output_action_select == ACT_SET) begin
        next_state = 1'b0;
      end
    end else if (waveform_mode_select != MODE_PHASE_PWM && match_hit) begin
      next_state = action_result(output_action_select, compare_output_state);
    end
  end

  // Mode changes never touch this register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      compare_output_state <= 1'b0;
    end else if (clk_en) begin
      compare_output_state <= next_state;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (flags_wr && wdata[`FLAG_OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      match_flag <= 1'b0;
    end else if (match_hit) begin
      match_flag <= 1'b1;
    end else if (flags_wr && wdata[`FLAG_MATCH_BIT]) begin
      match_flag <= 1'b0;
    end
  end

  // Pin override and driver enable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else if (clk_en) begin
      pin_out <= (output_action_select != ACT_NONE) ? compare_output_state
                                                    : port_value;
      pin_oe  <= pin_direction_bit;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence count_write_s;
    count_wr;
  endsequence

  sequence max_tick_s;
    timer_tick && !count_wr && count_value == `COUNT_MAX;
  endsequence

  sequence fast_pwm_bottom_s;
    max_tick_s ##0 waveform_mode_select == MODE_FAST_PWM
               ##0 output_action_select == ACT_CLEAR;
  endsequence

  overflow_set_a: assert property (max_tick_s |=> overflow_flag)
    else $error("overflow flag not set at wrap");

  wrap_zero_a: assert property (max_tick_s |=> count_value == `COUNT_BOTTOM)
    else $error("count did not wrap to zero");

  normal_count_a: assert property (
    timer_tick && !count_wr && waveform_mode_select == MODE_NORMAL
    |=> count_value == 8'($past(count_value) + `COUNT_STEP))
    else $error("normal mode did not increment");

  match_clear_a: assert property (
    match_hit && !count_wr && waveform_mode_select == MODE_CLEAR_ON_MATCH
    |=> count_value == `COUNT_BOTTOM && match_flag)
    else $error("clear-on-match did not clear");

  match_flag_a: assert property (match_hit |=> match_flag)
    else $error("match flag not set");

  write_block_a: assert property (count_write_s |=> !match_hit)
    else $error("match not blocked after count write");

  toggle_match_a: assert property (
    match_hit && !force_match_strobe && output_action_select == ACT_TOGGLE
    && waveform_mode_select == MODE_CLEAR_ON_MATCH
    |=> compare_output_state != $past(compare_output_state))
    else $error("output did not toggle on match");

  pwm_bottom_a: assert property (fast_pwm_bottom_s |=> compare_output_state)
    else $error("fast pwm did not set at bottom");

  no_action_a: assert property (
    clk_en && output_action_select == ACT_NONE
    |=> $stable(compare_output_state))
    else $error("output changed with no action selected");

  force_flag_a: assert property (
    force_match_strobe && !match_hit |=> match_flag == $past(match_flag))
    else $error("force strobe touched match flag");

  pin_source_a: assert property (
    clk_en && output_action_select != ACT_NONE
    |=> pin_out == $past(compare_output_state))
    else $error("pin not driven from output state");

  pin_enable_a: assert property (clk_en |=> pin_oe == $past(pin_direction_bit))
    else $error("pin enable does not follow direction");

  freeze_hold_a: assert property (
    !clk_en |=> $stable(count_value) && $stable(compare_output_state))
    else $error("state moved with clock enable low");

  pwm_match_clear_a: assert property (
    match_hit && !wrap && waveform_mode_select == MODE_FAST_PWM
    && output_action_select == ACT_CLEAR |=> !compare_output_state)
    else $error("fast pwm did not clear on match");

  pwm_invert_a: assert property (
    max_tick_s ##0 waveform_mode_select == MODE_FAST_PWM
               ##0 output_action_select == ACT_SET |=> !compare_output_state)
    else $error("inverted fast pwm did not clear at bottom");

  compare_hold_a: assert property (
    compare_wr && is_pwm && !wrap |=> compare_value == $past(compare_value))
    else $error("buffered compare value changed early");

  compare_direct_a: assert property (
    compare_wr && !is_pwm |=> compare_value == $past(wdata))
    else $error("direct compare value not written");

  force_no_clear_a: assert property (
    force_match_strobe && !timer_tick |=> count_value == $past(count_value))
    else $error("force strobe moved the count");

endmodule

`default_nettype wire

// File: test_timer8_compare_waveform_unit.sv
// Self-checking bench for the 8-bit compare and waveform timer
`timescale 1ns/100ps
`default_nettype none
`include "timer8_cfg.svh"

module test_timer8_compare_waveform_unit
  import timer8_pkg::*;
;
  typedef struct {
    string      name;
    logic [7:0] exp;
    int         kind;
  } note_t;

  logic               ref_clk;
  logic               reset_n;
  logic               clk_en;
  logic [`ADDR_W-1:0] addr;
  logic [7:0]         wdata;
  logic               wr_en;
  logic               rd_en;
  logic [7:0]         rdata;
  logic               pin_out;
  logic               pin_oe;
  logic               overflow_flag;
  logic               match_flag;
  logic               rd_d;
  logic               pin_req;
  logic               pin_d;
  logic [7:0]         last_rd;
  logic [31:0]        seed;
  int                 error_cnt;
  int                 compares;
  note_t              notes[$];
  action_t            fa[5] = '{ACT_TOGGLE, ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_NONE};
  logic               fs[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  prescale_t          pc[4] = '{PRESC_DIV8, PRESC_DIV64, PRESC_DIV256, PRESC_DIV1024};
  int                 pd[4] = '{8, 64, 256, 1024};

  timer8_compare_waveform_unit u_dut (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .clk_en        (clk_en),
    .addr          (addr),
    .wdata         (wdata),
    .wr_en         (wr_en),
    .rd_en         (rd_en),
    .rdata         (rdata),
    .pin_out       (pin_out),
    .pin_oe        (pin_oe),
    .overflow_flag (overflow_flag),
    .match_flag    (match_flag)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Marks the cycle in which a noted result is on the outputs
  always @(posedge ref_clk) begin
    rd_d  <= rd_en && clk_en;
    pin_d <= pin_req;
  end

  always @(negedge ref_clk) begin : monitor
    note_t      n;
    logic [7:0] seen;
    if ((rd_d === 1'b1 || pin_d === 1'b1) && notes.size() > 0) begin
      n = notes.pop_front();
      seen = (n.kind == 2) ? {6'h00, pin_oe, pin_out}
           : (n.kind == 4) ? {6'h00, match_flag, overflow_flag} : rdata;
      if (n.kind == 1) n.exp = last_rd + n.exp;
      if (rd_d === 1'b1) last_rd = rdata;
      if (n.kind != 3) begin
        compares++;
        if (seen !== n.exp) begin
          error_cnt++;
          $display("wrong value %s expected %h seen %h", n.name, n.exp, seen);
        end
      end
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  function automatic logic [7:0] ctrl(mode_t m, action_t a, prescale_t p, logic f);
    return (8'(f) << `CTRL_FORCE_BIT) | (8'(p) << `CTRL_PRESC_LSB)
           | (8'(a) << `CTRL_ACT_LSB) | (8'(m) << `CTRL_MODE_LSB);
  endfunction

  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [`ADDR_W-1:0] a, input logic [7:0] e, input string nm,
                    input int k = 0);
    notes.push_back('{nm, e, k});
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic pins(input logic oe, input logic out, input string nm);
    notes.push_back('{nm, {6'h00, oe, out}, 2});
    pin_req <= 1'b1;
    @(posedge ref_clk);
    pin_req <= 1'b0;
  endtask

  // Flag ports, match in bit 1 and overflow in bit 0
  task automatic flag_out(input logic [1:0] f, input string nm);
    notes.push_back('{nm, {6'h00, f}, 4});
    pin_req <= 1'b1;
    @(posedge ref_clk);
    pin_req <= 1'b0;
  endtask

  // Runs the timer for exactly n ticks at full rate, then stops it
  task automatic run(input int n, input mode_t m, input action_t a);
    wr(`OFS_CTRL, ctrl(m, a, PRESC_DIV1, 1'b0));
    repeat (n - 2) @(posedge ref_clk);
    wr(`OFS_CTRL, ctrl(m, a, PRESC_STOP, 1'b0));
  endtask

  task automatic setup(input logic [7:0] c, input logic [7:0] m);
    wr(`OFS_COUNT, c);
    wr(`OFS_COMPARE, m);
    wr(`OFS_FLAGS, 8'h03);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    addr = '0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    pin_req = 1'b0;
    last_rd = 8'h00;
    seed = 32'h7A23;
    error_cnt = 0;
    compares = 0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) rd(3'(i), 8'h00, "reset register");
    wr(`OFS_PORT, 8'h03);
    pins(1'b1, 1'b1, "port value");
    wr(`OFS_CTRL, ctrl(MODE_NORMAL, ACT_TOGGLE, PRESC_STOP, 1'b0));
    pins(1'b1, 1'b0, "reset state");
    wr(`OFS_PORT, 8'h01);
    pins(1'b0, 1'b0, "driver off");
    $display("test reset done");
    foreach (fa[i]) begin
      wr(`OFS_CTRL, ctrl(MODE_NORMAL, fa[i], PRESC_STOP, 1'b0));
      wr(`OFS_CTRL, ctrl(MODE_NORMAL, fa[i], PRESC_STOP, 1'b1));
      wr(`OFS_CTRL, ctrl(MODE_NORMAL, ACT_TOGGLE, PRESC_STOP, 1'b0));
      pins(1'b0, fs[i], "forced state");
    end
    wr(`OFS_PORT, 8'h02);
    rd(`OFS_FLAGS, 8'h00, "flags after force");
    rd(`OFS_CTRL, ctrl(MODE_NORMAL, ACT_TOGGLE, PRESC_STOP, 1'b0), "control");
    wr(`OFS_CTRL, ctrl(MODE_FAST_PWM, ACT_TOGGLE, PRESC_STOP, 1'b0));
    pins(1'b1, 1'b1, "state after mode change");
    wr(`OFS_CTRL, ctrl(MODE_FAST_PWM, ACT_CLEAR, PRESC_STOP, 1'b1));
    pins(1'b1, 1'b1, "force refused in pwm");
    wr(`OFS_CTRL, ctrl(MODE_PHASE_PWM, ACT_CLEAR, PRESC_STOP, 1'b0));
    wr(`OFS_CTRL, ctrl(MODE_PHASE_PWM, ACT_CLEAR, PRESC_STOP, 1'b1));
    pins(1'b1, 1'b1, "force refused in phase pwm");
    $display("test force done");
    wr(`OFS_CTRL, ctrl(MODE_NORMAL, ACT_NONE, PRESC_STOP, 1'b0));
    repeat (4) begin
      seed = xs(seed);
      wr(`OFS_COUNT, seed[7:0]);
      wr(`OFS_COMPARE, seed[15:8]);
      rd(`OFS_COUNT, seed[7:0], "count");
      rd(`OFS_COMPARE, seed[15:8], "compare");
    end
    clk_en <= 1'b0;
    wr(`OFS_COUNT, 8'h77);
    clk_en <= 1'b1;
    rd(`OFS_COUNT, seed[7:0], "count after dropped write");
    $display("test registers done");
    setup(8'hFD, 8'h80);
    run(2, MODE_NORMAL, ACT_NONE);
    rd(`OFS_COUNT, 8'hFF, "count at max");
    rd(`OFS_FLAGS, 8'h00, "flags before wrap");
    run(2, MODE_NORMAL, ACT_NONE);
    rd(`OFS_COUNT, 8'h01, "count after wrap");
    rd(`OFS_FLAGS, 8'h01, "flags after wrap");
    flag_out(2'h1, "overflow port");
    setup(8'h1E, 8'h20);
    run(2, MODE_NORMAL, ACT_NONE);
    rd(`OFS_FLAGS, 8'h00, "flags at match value");
    run(2, MODE_NORMAL, ACT_NONE);
    rd(`OFS_FLAGS, 8'h02, "flags after match");
    rd(`OFS_COUNT, 8'h22, "count through match");
    setup(8'h20, 8'h20);
    run(2, MODE_NORMAL, ACT_NONE);
    rd(`OFS_FLAGS, 8'h00, "flags with blocked match");
    wr(`OFS_CTRL, ctrl(MODE_NORMAL, ACT_TOGGLE, PRESC_STOP, 1'b0));
    pins(1'b1, 1'b1, "state kept on no action");
    $display("test normal done");
    setup(8'h00, 8'h03);
    run(4, MODE_CLEAR_ON_MATCH, ACT_TOGGLE);
    rd(`OFS_COUNT, 8'h00, "count cleared on match");
    rd(`OFS_FLAGS, 8'h02, "flags on match");
    pins(1'b1, 1'b0, "toggled state");
    wr(`OFS_COMPARE, 8'h00);
    run(3, MODE_CLEAR_ON_MATCH, ACT_TOGGLE);
    rd(`OFS_COUNT, 8'h00, "count at compare zero");
    pins(1'b1, 1'b1, "toggle every tick");
    setup(8'hFE, 8'h05);
    run(2, MODE_CLEAR_ON_MATCH, ACT_NONE);
    rd(`OFS_COUNT, 8'h00, "count after missed match");
    rd(`OFS_FLAGS, 8'h01, "flags at wrap");
    run(6, MODE_CLEAR_ON_MATCH, ACT_NONE);
    rd(`OFS_COUNT, 8'h00, "count after late match");
    rd(`OFS_FLAGS, 8'h03, "flags after late match");
    $display("test clear on match done");
    wr(`OFS_CTRL, ctrl(MODE_FAST_PWM, ACT_CLEAR, PRESC_STOP, 1'b0));
    setup(8'hFE, 8'h40);
    run(2, MODE_FAST_PWM, ACT_CLEAR);
    rd(`OFS_FLAGS, 8'h01, "pwm overflow");
    pins(1'b1, 1'b1, "set at bottom");
    run(64, MODE_FAST_PWM, ACT_CLEAR);
    rd(`OFS_COUNT, 8'h40, "pwm count");
    pins(1'b1, 1'b1, "held before match");
    run(2, MODE_FAST_PWM, ACT_CLEAR);
    pins(1'b1, 1'b0, "cleared on match");
    rd(`OFS_FLAGS, 8'h03, "pwm match flag");
    flag_out(2'h3, "flag ports");
    wr(`OFS_CTRL, ctrl(MODE_FAST_PWM, ACT_SET, PRESC_STOP, 1'b0));
    wr(`OFS_COMPARE, 8'h50);
    run(16, MODE_FAST_PWM, ACT_SET);
    rd(`OFS_COUNT, 8'h52, "pwm count past new compare");
    pins(1'b1, 1'b0, "buffered compare waits");
    wr(`OFS_FLAGS, 8'h03);
    run(174, MODE_FAST_PWM, ACT_SET);
    rd(`OFS_COUNT, 8'h00, "pwm period end");
    rd(`OFS_FLAGS, 8'h01, "pwm overflow at max");
    pins(1'b1, 1'b0, "inverted cleared at bottom");
    run(82, MODE_FAST_PWM, ACT_SET);
    pins(1'b1, 1'b1, "inverted set on match");
    $display("test fast pwm done");
    foreach (pc[i]) begin
      wr(`OFS_CTRL, ctrl(MODE_NORMAL, ACT_NONE, pc[i], 1'b0));
      rd(`OFS_COUNT, 8'h00, "count base", 3);
      repeat (2 * pd[i] - 2) @(posedge ref_clk);
      rd(`OFS_COUNT, 8'h02, "prescaled ticks", 1);
    end
    $display("test prescaler done");
    tally_and_finish();
  end

endmodule
`default_nettype wire
